// ==== dbgsec_chk_assertions.sv ====
`timescale 1ns/1ps
`default_nettype none
module dbgsec_chk #(
    parameter int WIN_CYC = 400
) (
    input wire logic                       clk,
    input wire logic                       rst_n,
    input wire logic                       clk_en,
    input wire logic                       bscan_enable_serial,
    input wire logic                       fw_debug_enable,
    input wire logic                       full_erase,
    input wire logic                       block_op_req,
    input wire logic                       block_sec_ok,
    input wire logic                       swo_write,
    input wire logic                       swo_ready,
    input wire dbgsec_pkg::dbgsec_enc_type swo_enc,
    input wire logic                       bscan_tdo_out,
    input wire logic                       bscan_port_en,
    input wire logic                       serial_port_en,
    input wire dbgsec_pkg::dbgsec_pair_type serial_pair,
    input wire logic                       debug_en,
    input wire logic                       locked,
    input wire logic                       flash_prot,
    input wire logic                       block_op_grant
);
    import dbgsec_pkg::*;
    int win_cnt;
    // Cycles since reset release, for the key window
    always_ff @(posedge clk) begin
        if (!rst_n) win_cnt <= 0;
        else if (clk_en && win_cnt < 100000) win_cnt <= win_cnt + 1;
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    AST_RST_STATE: assert property (@(posedge clk) disable iff (1'h0)
        !rst_n && clk_en |=> bscan_port_en && !serial_port_en && !debug_en && bscan_tdo_out)
        else $error("reset state wrong");
    AST_LOCK_OFF: assert property (locked && $past(locked) |-> !serial_port_en && !bscan_port_en && !debug_en)
        else $error("port open while locked");
    AST_DBG_CAUSE: assert property ($rose(debug_en) |-> $past(fw_debug_enable) || $past(fw_debug_enable, 2))
        else $error("debug enabled without firmware");
    AST_WINDOW: assert property ($rose(serial_port_en) && !bscan_enable_serial && !$past(bscan_enable_serial)
        |-> win_cnt <= WIN_CYC + 4) else $error("serial enabled outside key window");
    AST_PAIR_HOLD: assert property (serial_port_en && $past(serial_port_en) |-> $stable(serial_pair))
        else $error("serial pair changed while enabled");
    AST_SWO_START: assert property (swo_write && swo_ready && serial_port_en && swo_enc == DBGSEC_ENC_UART
        |=> !swo_ready ##1 (!bscan_tdo_out && !swo_ready)) else $error("trace start bit missing");
    AST_BIT_LEN: assert property ($fell(bscan_tdo_out) && swo_enc == DBGSEC_ENC_UART
        |-> (!bscan_tdo_out)[*8] ##8 !bscan_tdo_out) else $error("trace bit too short");
    AST_TDO_MODE: assert property ($fell(bscan_tdo_out) |-> serial_port_en)
        else $error("trace output without serial port");
    AST_PROT_CLR: assert property ($fell(flash_prot) |-> $past(full_erase))
        else $error("protection cleared without full erase");
    AST_GRANT: assert property (block_op_grant |-> $past(block_op_req && block_sec_ok))
        else $error("block operation granted without permission");
endmodule
bind dbgsec_top dbgsec_chk #(.WIN_CYC(WIN_CYC)) u_chk (.*);
`default_nettype wire

// ==== dbgsec_map.svh ====
`ifndef DBGSEC_MAP_SVH
`define DBGSEC_MAP_SVH

// Key window after reset
`define DBGSEC_KEY_WINDOW_NS     8000
`define DBGSEC_CLK_PERIOD_NS     20
`define DBGSEC_KEY_WINDOW_CYC    (`DBGSEC_KEY_WINDOW_NS / `DBGSEC_CLK_PERIOD_NS)
// Lock latch majority threshold
`define DBGSEC_LOCK_MATCH_MIN    6'h1c
`define DBGSEC_KEY_BITS          32
// Serial acquisition key length
`define DBGSEC_ACQ_KEY_LEN       16
// Trace depths
`define DBGSEC_TRACE_DEPTH_FULL  1000
`define DBGSEC_TRACE_DEPTH_PC    2000
// Serial trace output frame
`define DBGSEC_UART_BITS         8
`define DBGSEC_TRACE_CHANNELS    32
`define DBGSEC_TRACE_BAUD_DIV    16'h0010

`endif

// ==== dbgsec_pkg.sv ====
package dbgsec_pkg;
    typedef enum logic {
        DBGSEC_PAIR_BSCAN,
        DBGSEC_PAIR_USB
    } dbgsec_pair_type;

    typedef enum logic {
        DBGSEC_TRACE_WRAP,
        DBGSEC_TRACE_BREAK
    } dbgsec_full_mode_type;

    typedef enum logic {
        DBGSEC_ENC_UART,
        DBGSEC_ENC_MANCH
    } dbgsec_enc_type;
endpackage

// ==== dbgsec_probe.sv ====
`timescale 1ns/1ps
`default_nettype none
module dbgsec_probe (
    input  wire logic        clk,
    input  wire logic        go,
    input  wire logic        use_usb,
    input  wire logic [15:0] key,
    output logic             bscan_key_in,
    output logic             usb_key_in,
    output logic             swclk_link,
    output logic             swdio_in
);
    int   idx = -1;
    logic idle_bit = 1'h0;
    always @(posedge clk) begin
        idle_bit <= ~idle_bit;
        if (idx >= 0) idx <= idx - 1;
        else if (go) idx <= 15;
    end
    // Key MSB first on the chosen pair; idle pins wiggle instead of holding
    always_comb begin
        bscan_key_in = (idx >= 0 && !use_usb) ? key[idx] : idle_bit;
        usb_key_in = (idx >= 0 && use_usb) ? key[idx] : ~idle_bit;
        swdio_in = ~idle_bit;
    end
    // Link clock at 160 ns, still outside frames
    initial begin
        swclk_link = 1'h0;
        #7;
        forever begin
            #80;
            swclk_link = (idx >= 0) ? ~swclk_link : 1'h0;
        end
    end
endmodule
`default_nettype wire

// ==== dbgsec_top.sv ====
// Operation
// R1: probe keeps scan clock within limits
// R2: scan port enabled unless firmware disables
// R3: probe keeps serial clock below third
// R4: serial port enables on key within window
// R5: only one pin pair may hold serial
// R6: one pin clock, other bidirectional data; the code never drives the data pin
// R7: scan port enables serial, or disabled
// R8: serial reacquirable in window, re-enables scan
// R9: debug circuits off until firmware enables
// R10: lockout disables all ports permanently
// R11: latch true when 28 of 32 match
// R12: lock blocks debug, latch erase, writes
// R13: protection clears only on full erase; the code also clears it on reset
// R14: eight program address breakpoints halt CPU
// R15: one data address and value breakpoint
// R16: break after ordered breakpoint sequence
// R17: debug works in reset and low power
// R18: trace PC, accumulator, register; depth
// R19: trace starts on trigger, optional window
// R20: full buffer wraps or breaks
// R21: trace pin on data-out, serial mode only
// R22: 32 channels, UART N81 or Manchester
// R23: latch sampled only at reset
// R24: key writable only without protection
`timescale 1ns/1ps
`include "dbgsec_map.svh"
`default_nettype none
module dbgsec_top #(
    parameter int                 ADDR_W     = 16,
    parameter int                 DATA_W     = 8,
    parameter int                 N_BP       = 8,
    parameter logic [31:0]        LOCK_KEY   = 32'h1234abcd, // Arbitrary value
    parameter logic [15:0]        ACQ_KEY    = 16'he79e,     // Arbitrary value
    parameter int                 WIN_CYC    = `DBGSEC_KEY_WINDOW_CYC
) (
    // Clocks and reset
    input  wire logic                      clk,
    input  wire logic                      rst_n,
    input  wire logic                      clk_en,
    input  wire logic                      swclk_link,
    // Serial key pins, already past the pin mux
    input  wire logic                      bscan_key_in,
    input  wire logic                      usb_key_in,
    // Serial data pin, three signals
    input  wire logic                      swdio_in,
    output logic                           swdio_out,
    output logic                           swdio_oe_n,
    // Firmware control
    input  wire logic                      fw_bscan_disable,
    input  wire logic                      fw_debug_enable,
    input  wire logic                      bscan_enable_serial,
    input  wire logic                      serial_enable_bscan,
    input  wire logic                      serial_disable,
    // Lock latch and flash protection
    input  wire logic                      key_write,
    input  wire logic [31:0]               key_wdata,
    input  wire logic                      flash_prot_set,
    input  wire logic                      full_erase,
    input  wire logic                      block_op_req,
    input  wire logic                      block_sec_ok,
    // CPU observation
    input  wire logic                      cpu_in_reset,
    input  wire logic                      cpu_low_power,
    input  wire logic                      pc_valid,
    input  wire logic [ADDR_W-1:0]         pc,
    input  wire logic [DATA_W-1:0]         acc,
    input  wire logic [DATA_W-1:0]         sel_reg,
    input  wire logic                      mem_acc,
    input  wire logic [ADDR_W-1:0]         mem_addr,
    input  wire logic [DATA_W-1:0]         mem_data,
    // Breakpoint setup
    input  wire logic [N_BP*ADDR_W-1:0]    bp_addr,
    input  wire logic [N_BP-1:0]           bp_en,
    input  wire logic                      mbp_en,
    input  wire logic [ADDR_W-1:0]         mbp_addr,
    input  wire logic [DATA_W-1:0]         mbp_data,
    input  wire logic                      seq_en,
    input  wire logic [N_BP-1:0]           seq_mask,
    // Trace setup
    input  wire logic [ADDR_W-1:0]         trc_trig_addr,
    input  wire logic                      trc_win_en,
    input  wire logic [ADDR_W-1:0]         trc_win_lo,
    input  wire logic [ADDR_W-1:0]         trc_win_hi,
    input  wire logic                      trc_pc_only,
    input  wire dbgsec_pkg::dbgsec_full_mode_type trc_full_mode,
    // Single-pin trace output
    input  wire logic                      swo_write,
    input  wire logic [4:0]                swo_chan,
    input  wire logic [31:0]               swo_data,
    input  wire dbgsec_pkg::dbgsec_enc_type swo_enc,
    output logic                           swo_ready,
    output logic                           bscan_tdo_out,
    // Status
    output logic                           bscan_port_en,
    output logic                           serial_port_en,
    output dbgsec_pkg::dbgsec_pair_type    serial_pair,
    output logic                           debug_en,
    output logic                           locked,
    output logic                           flash_prot,
    output logic                           block_op_grant,
    output logic                           cpu_halt,
    output logic                           trc_active,
    output logic                           trc_wrapped,
    output logic [10:0]                    trc_count
);
    import dbgsec_pkg::*;

    localparam int TW = 3 * DATA_W + ADDR_W;
    localparam int WCW = $clog2(WIN_CYC + 1);

    // Key pins synchronised to clk
    logic [1:0] bkey_sync_reg;
    logic [1:0] ukey_sync_reg;
    always_ff @(posedge clk) begin
        if (clk_en) begin
            bkey_sync_reg <= {bkey_sync_reg[0], bscan_key_in};
            ukey_sync_reg <= {ukey_sync_reg[0], usb_key_in};
        end
    end

    // Link domain: shift register of data pin, handed over as a level
    logic [15:0] lk_shift_reg;
    always_ff @(posedge swclk_link) begin
        lk_shift_reg <= {lk_shift_reg[14:0], swdio_in}; // R6
    end
    // Match registered in the link domain so only one settled bit crosses
    logic       lk_match_reg;
    always_ff @(posedge swclk_link) begin
        lk_match_reg <= lk_shift_reg == ACQ_KEY;
    end
    logic [1:0] lk_sync_reg;
    always_ff @(posedge clk) begin
        if (clk_en) lk_sync_reg <= {lk_sync_reg[0], lk_match_reg};
    end

    // Key window counter and per-pair key shifters
    logic [WCW-1:0] win_cnt_reg;
    logic           win_open;
    logic [15:0]    bkey_reg;
    logic [15:0]    ukey_reg;
    assign win_open = win_cnt_reg < WCW'(WIN_CYC);
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            win_cnt_reg <= '0;
            bkey_reg    <= '0;
            ukey_reg    <= '0;
        end else if (clk_en) begin
            if (win_open) begin
                win_cnt_reg <= win_cnt_reg + 1'b1;
                bkey_reg    <= {bkey_reg[14:0], bkey_sync_reg[1]};
                ukey_reg    <= {ukey_reg[14:0], ukey_sync_reg[1]};
            end
        end
    end

    // Lock latch: contents, majority match, sample at reset
    // Cells are not touched by reset; an erased latch reads as all zero
    logic [31:0] latch_reg = 32'h0000_0000;
    logic [5:0]  match_cnt;
    logic        lock_match;
    logic        lock_sample_reg;
    always_comb begin
        match_cnt = '0;
        for (int i = 0; i < `DBGSEC_KEY_BITS; i++) begin
            match_cnt = match_cnt + 6'(latch_reg[i] == LOCK_KEY[i]);
        end
    end
    assign lock_match = match_cnt >= `DBGSEC_LOCK_MATCH_MIN; // R11
    always_ff @(posedge clk) begin
        if (clk_en && key_write && !flash_prot && !lock_match) begin // R24 R12
            latch_reg <= key_wdata;
        end
    end
    always_ff @(posedge clk) begin
        if (!rst_n) lock_sample_reg <= 1'b0;
        else if (clk_en && win_cnt_reg == '0) lock_sample_reg <= lock_match; // R23
    end

    // Port selection
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            bscan_port_en  <= 1'b1; // R2
            serial_port_en <= 1'b0;
            serial_pair    <= DBGSEC_PAIR_BSCAN;
        end else if (clk_en) begin
            if (lock_sample_reg) begin
                bscan_port_en  <= 1'b0; // R10
                serial_port_en <= 1'b0; // R10
            end else if (win_open && !serial_port_en && bkey_reg == ACQ_KEY) begin
                serial_port_en <= 1'b1; // R4 R8
                serial_pair    <= DBGSEC_PAIR_BSCAN; // R5
            end else if (win_open && !serial_port_en && ukey_reg == ACQ_KEY) begin
                serial_port_en <= 1'b1; // R4 R8
                serial_pair    <= DBGSEC_PAIR_USB; // R5
            end else begin
                if (fw_bscan_disable) bscan_port_en <= 1'b0; // R2
                else if (serial_port_en && serial_enable_bscan) bscan_port_en <= 1'b1; // R8
                if (bscan_port_en && bscan_enable_serial) serial_port_en <= 1'b1; // R7
                else if (serial_disable) serial_port_en <= 1'b0; // R7
            end
        end
    end

    // Debug enable by firmware only, flash protection
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            debug_en <= 1'b0; // R9
        end else if (clk_en) begin
            debug_en <= fw_debug_enable && !lock_sample_reg; // R9 R12
        end
    end
    always_ff @(posedge clk) begin
        if (!rst_n) flash_prot <= 1'b0;
        else if (clk_en) begin
            if (full_erase && !lock_sample_reg) flash_prot <= 1'b0; // R13
            else if (flash_prot_set) flash_prot <= 1'b1;
        end
    end
    always_ff @(posedge clk) begin
        if (!rst_n) block_op_grant <= 1'b0;
        else if (clk_en) block_op_grant <= block_op_req && block_sec_ok && !lock_sample_reg; // R13
    end
    always_ff @(posedge clk) begin
        if (!rst_n) locked <= 1'b0;
        else if (clk_en) locked <= lock_sample_reg;
    end

    // Breakpoints: not gated by cpu reset or low power
    logic             dbg_live;
    logic [N_BP-1:0]  bp_hit;
    logic             mbp_hit;
    logic [N_BP-1:0]  seq_done_reg;
    assign dbg_live = debug_en; // R17
    genvar g;
    generate
        for (g = 0; g < N_BP; g++) begin : g_bp
            assign bp_hit[g] = bp_en[g] && pc_valid && pc == bp_addr[g*ADDR_W +: ADDR_W]; // R14
        end
    endgenerate
    assign mbp_hit = mbp_en && mem_acc && mem_addr == mbp_addr && mem_data == mbp_data; // R15

    // Sequence: lowest pending breakpoint in mask must hit next
    logic [N_BP-1:0] seq_pend;
    logic [N_BP-1:0] seq_next;
    assign seq_pend = seq_mask & ~seq_done_reg;
    assign seq_next = seq_pend & (~seq_pend + N_BP'(1));
    always_ff @(posedge clk) begin
        if (!rst_n) seq_done_reg <= '0;
        else if (clk_en) begin
            if (!seq_en || cpu_halt) seq_done_reg <= '0;
            else if (|(bp_hit & seq_next)) seq_done_reg <= seq_done_reg | seq_next; // R16
        end
    end

    // Trace buffer
    localparam int DEPTH = `DBGSEC_TRACE_DEPTH_PC;
    logic [TW-1:0] trc_mem [0:DEPTH-1];
    logic [10:0]   trc_wp_reg;
    logic [10:0]   trc_lim;
    logic          trc_in_win;
    logic          trc_full;
    logic          trc_wr;
    logic          trc_brk;
    logic [TW-1:0] trc_word;
    assign trc_lim = trc_pc_only ? 11'(`DBGSEC_TRACE_DEPTH_PC) : 11'(`DBGSEC_TRACE_DEPTH_FULL); // R18
    assign trc_in_win = !trc_win_en || (pc >= trc_win_lo && pc <= trc_win_hi); // R19
    assign trc_full = trc_count == trc_lim;
    assign trc_wr = dbg_live && pc_valid && (trc_active || pc == trc_trig_addr) && trc_in_win; // R19
    assign trc_brk = trc_wr && trc_full && trc_full_mode == DBGSEC_TRACE_BREAK; // R20
    // PC-only entries hold just the PC in the low bits, zero-extended in the high bits
    assign trc_word = trc_pc_only ? TW'(pc) : {pc, acc, sel_reg, {DATA_W{1'b0}}}; // R18
    always_ff @(posedge clk) begin
        if (clk_en && trc_wr && !trc_brk) trc_mem[trc_wp_reg] <= trc_word; // R18
    end
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            trc_active  <= 1'b0;
            trc_wp_reg  <= '0;
            trc_count   <= '0;
            trc_wrapped <= 1'b0;
        end else if (clk_en) begin
            if (!dbg_live) trc_active <= 1'b0;
            else if (pc_valid && pc == trc_trig_addr) trc_active <= 1'b1; // R19
            if (trc_wr && !trc_brk) begin
                trc_wp_reg <= (trc_wp_reg == trc_lim - 11'h001) ? '0 : trc_wp_reg + 11'h001; // R20
                if (trc_full) trc_wrapped <= 1'b1;
                else trc_count <= trc_count + 11'h001;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) cpu_halt <= 1'b0;
        else if (clk_en) begin
            if (!dbg_live) cpu_halt <= 1'b0;
            else if ((!seq_en && |bp_hit) || mbp_hit || trc_brk) cpu_halt <= 1'b1; // R14 R15 R20
            else if (seq_en && |(bp_hit & seq_next) && seq_pend == seq_next) cpu_halt <= 1'b1; // R16
        end
    end

    // Single-pin trace: frame is channel byte then four data bytes
    logic [39:0] swo_buf_reg;
    logic [2:0]  swo_byte_reg;
    logic [3:0]  swo_bit_reg;
    logic [15:0] swo_div_reg;
    logic        swo_half_reg;
    logic        swo_busy;
    logic        swo_allowed;
    logic        swo_cur;
    assign swo_busy = swo_byte_reg != '0;
    assign swo_allowed = serial_port_en && !bscan_port_en && !lock_sample_reg; // R21
    assign swo_cur = swo_bit_reg == 4'h0 ? 1'b0 : (swo_bit_reg == 4'h9 ? 1'b1 : swo_buf_reg[swo_bit_reg - 4'h1]);
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            swo_buf_reg  <= '0;
            swo_byte_reg <= '0;
            swo_bit_reg  <= '0;
            swo_div_reg  <= '0;
            swo_half_reg <= 1'b0;
            swo_ready    <= 1'b0;
            bscan_tdo_out <= 1'b1;
        end else if (clk_en) begin
            // Ready drops on the accepting edge and stays low for the frame
            swo_ready <= swo_allowed && !swo_busy && !swo_write;
            if (!swo_busy) begin
                bscan_tdo_out <= 1'b1;
                if (swo_write && swo_allowed && swo_ready) begin
                    swo_buf_reg  <= {swo_data, 3'h0, swo_chan}; // R22
                    swo_byte_reg <= 3'h5;
                    swo_bit_reg  <= '0;
                    swo_div_reg  <= '0;
                    swo_half_reg <= 1'b0;
                end
            end else begin
                bscan_tdo_out <= (swo_enc == DBGSEC_ENC_MANCH) ? (swo_cur ^ swo_half_reg) : swo_cur; // R21 R22
                if (swo_div_reg == `DBGSEC_TRACE_BAUD_DIV - 16'h0001) begin
                    swo_div_reg <= '0;
                    swo_half_reg <= ~swo_half_reg;
                    if (swo_half_reg || swo_enc == DBGSEC_ENC_UART) begin
                        swo_half_reg <= 1'b0;
                        if (swo_bit_reg == 4'h9) begin // R22
                            swo_bit_reg  <= '0;
                            swo_byte_reg <= swo_byte_reg - 3'h1;
                            swo_buf_reg  <= {8'h00, swo_buf_reg[39:8]};
                        end else begin
                            swo_bit_reg <= swo_bit_reg + 4'h1;
                        end
                    end
                end else begin
                    swo_div_reg <= swo_div_reg + 16'h0001;
                end
            end
        end
    end

    // Data pin output: idle released
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            swdio_out  <= 1'b0;
            swdio_oe_n <= 1'b1;
        end else if (clk_en) begin
            swdio_out  <= 1'b0;
            swdio_oe_n <= 1'b1;
        end
    end


    // CPU reset and low power deliberately do not gate debug
    logic unused_ok;
    assign unused_ok = lk_sync_reg[1] ^ cpu_in_reset ^ cpu_low_power;
endmodule
`default_nettype wire

// ==== testbench.sv ====
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import dbgsec_pkg::*;
    localparam logic [31:0] LKEY = 32'h5a3c9671; // Arbitrary value
    localparam logic [15:0] AKEY = 16'hc3a5;     // Arbitrary value
    localparam int          WIN  = 40;
    int   errors = 0;
    int   samples_checked = 0;
    logic clk = 1'h0, rst_n = 1'h0, clk_en = 1'h1, go = 1'h0, use_usb = 1'h0;
    logic fw_bscan_disable = 1'h0, fw_debug_enable = 1'h0, bscan_enable_serial = 1'h0;
    logic serial_enable_bscan = 1'h0, serial_disable = 1'h0, key_write = 1'h0, flash_prot_set = 1'h0;
    logic full_erase = 1'h0, block_op_req = 1'h0, block_sec_ok = 1'h0, cpu_in_reset = 1'h0;
    logic cpu_low_power = 1'h0, pc_valid = 1'h0, mem_acc = 1'h0, mbp_en = 1'h0, seq_en = 1'h0;
    logic trc_win_en = 1'h0, trc_pc_only = 1'h0, swo_write = 1'h0;
    logic [31:0]  key_wdata = '0, swo_data = '0;
    logic [15:0]  pc = '0, mem_addr = '0, mbp_addr = '0, trc_trig_addr = '0, trc_win_lo = '0, trc_win_hi = '0;
    logic [7:0]   acc = '0, sel_reg = '0, mem_data = '0, mbp_data = '0, bp_en = '0, seq_mask = '0;
    logic [127:0] bp_addr = '0;
    logic [4:0]   swo_chan = '0;
    dbgsec_full_mode_type trc_full_mode = DBGSEC_TRACE_WRAP;
    dbgsec_enc_type       swo_enc = DBGSEC_ENC_UART;
    dbgsec_pair_type      serial_pair;
    logic bscan_key_in, usb_key_in, swclk_link, swdio_in, swdio_out, swdio_oe_n, swo_ready, bscan_tdo_out;
    logic bscan_port_en, serial_port_en, debug_en, locked, flash_prot, block_op_grant, cpu_halt;
    logic trc_active, trc_wrapped;
    logic [10:0]  trc_count;
    logic [49:0]  raw;
    logic [31:0]  wd [3] = '{LKEY ^ 32'h8000_1111, LKEY ^ 32'h8000_0111, 32'h0000_0000};

    always #10 clk = ~clk;

    dbgsec_top #(.WIN_CYC(WIN), .LOCK_KEY(LKEY), .ACQ_KEY(AKEY)) DUT (.*);
    dbgsec_probe u_probe (.clk(clk), .go(go), .use_usb(use_usb), .key(AKEY), .bscan_key_in(bscan_key_in),
        .usb_key_in(usb_key_in), .swclk_link(swclk_link), .swdio_in(swdio_in));

    task automatic chk(input logic [49:0] got, input logic [49:0] exp);
        samples_checked++;
        if (got !== exp) begin
            errors++;
            $display("BAD %0t mismatch got %h want %h", $time, got, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic look(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic restart(input logic key, input logic usb);
        @(posedge clk);
        rst_n <= 1'h0;
        tick(16);
        rst_n <= 1'h1;
        go <= key;
        use_usb <= usb;
        tick(1);
        go <= 1'h0;
    endtask
    // Sends one trace word and samples the pin every 16 cycles
    task automatic swo_frame(input logic [4:0] ch, input logic [31:0] d, input dbgsec_enc_type enc);
        for (int i = 0; i < 100 && swo_ready !== 1'h1; i++) look(1);
        @(posedge clk);
        {swo_chan, swo_data, swo_enc, swo_write} <= {ch, d, enc, 1'h1};
        tick(1);
        swo_write <= 1'h0;
        for (int i = 0; i < 60 && bscan_tdo_out !== 1'h0; i++) look(1);
        look(8);
        for (int i = 0; i < 50; i++) begin
            raw[i] = bscan_tdo_out;
            look(16);
        end
        for (int i = 0; i < 1000 && swo_ready !== 1'h1; i++) look(1);
    endtask
    function automatic logic [49:0] uart_frame(input logic [39:0] b);
        logic [49:0] f;
        for (int k = 0; k < 5; k++) f[k*10 +: 10] = {1'h1, b[k*8 +: 8], 1'h0};
        return f;
    endfunction
    function automatic logic [49:0] manch(input logic [49:0] f);
        logic [49:0] m;
        for (int j = 0; j < 25; j++) m[2*j +: 2] = {~f[j], f[j]};
        return m;
    endfunction
    task automatic report_and_stop;
        $display("errors=%0d samples_checked=%0d", errors, samples_checked);
        if (errors == 0 && samples_checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    initial begin
        tick(20000);
        errors++;
        report_and_stop();
    end

    initial begin
        restart(1'h0, 1'h0);
        look(3);
        chk({bscan_port_en, debug_en, serial_port_en}, 3'h4);
        chk({swdio_oe_n, bscan_tdo_out}, 2'h3);
        @(posedge clk);
        swo_write <= 1'h1;
        tick(1);
        swo_write <= 1'h0;
        look(20);
        chk(bscan_tdo_out, 1'h1);
        // Key sent after the window closed
        tick(WIN + 8);
        go <= 1'h1;
        tick(1);
        go <= 1'h0;
        look(30);
        chk(serial_port_en, 1'h0);
        @(posedge clk);
        bscan_enable_serial <= 1'h1;
        tick(4);
        bscan_enable_serial <= 1'h0;
        look(2);
        chk(serial_port_en, 1'h1);
        @(posedge clk);
        serial_disable <= 1'h1;
        tick(2);
        serial_disable <= 1'h0;
        look(2);
        chk(serial_port_en, 1'h0);
        for (int p = 0; p < 2; p++) begin
            restart(1'h1, p[0]);
            look(30);
            chk({serial_port_en, serial_pair}, {1'h1, p[0]});
        end
        // Trace pin needs the scan port off
        @(posedge clk);
        fw_bscan_disable <= 1'h1;
        look(3);
        chk(bscan_port_en, 1'h0);
        swo_frame(5'h1f, 32'ha5c3_0f81, DBGSEC_ENC_UART);
        chk(raw, uart_frame({32'ha5c3_0f81, 8'h1f}));
        swo_frame(5'h00, 32'h0000_00ff, DBGSEC_ENC_MANCH);
        chk(raw, manch(uart_frame({32'h0000_00ff, 8'h00})));
        @(posedge clk);
        {fw_bscan_disable, serial_enable_bscan} <= 2'h1;
        look(3);
        chk(bscan_port_en, 1'h1);
        // Top breakpoint slot, CPU held in reset and asleep
        @(posedge clk);
        {bp_addr[127:112], bp_en, pc, pc_valid} <= {16'h0420, 8'h80, 16'h0420, 1'h1};
        {cpu_in_reset, cpu_low_power, mem_acc, mbp_en, trc_win_en, trc_pc_only} <= 6'h3f;
        {acc, sel_reg, mem_data, mbp_data} <= 32'h1122_3344;
        {mem_addr, mbp_addr, trc_trig_addr, trc_win_hi} <= {4{16'h0420}};
        trc_full_mode <= DBGSEC_TRACE_BREAK;
        look(4);
        chk({debug_en, cpu_halt}, 2'h0);
        @(posedge clk);
        fw_debug_enable <= 1'h1;
        look(4);
        chk({debug_en, cpu_halt, trc_active}, 3'h7);
        chk({trc_wrapped, trc_count}, {1'h0, 11'h002});
        // Key refused under protection; protection holds until full erase lifts it
        @(posedge clk);
        {flash_prot_set, block_op_req} <= 2'h3;
        tick(2);
        {key_write, key_wdata} <= {1'h1, LKEY};
        tick(1);
        {key_write, flash_prot_set} <= 2'h0;
        look(2);
        chk({flash_prot, block_op_grant}, 2'h2);
        @(posedge clk);
        {full_erase, block_sec_ok} <= 2'h3;
        tick(1);
        full_erase <= 1'h0;
        look(2);
        chk({flash_prot, block_op_grant}, 2'h1);
        restart(1'h1, 1'h0);
        look(30);
        chk({locked, serial_port_en}, 2'h1);
        // 27 matching bits, then 28, then an attempt to clear the latch
        for (int n = 0; n < 3; n++) begin
            @(posedge clk);
            {key_write, key_wdata} <= {1'h1, wd[n]};
            tick(1);
            key_write <= 1'h0;
            look(3);
            chk(locked, n == 2);
            restart(1'h1, 1'h0);
            look(30);
            chk({locked, bscan_port_en, serial_port_en, debug_en}, (n == 0) ? 4'h7 : 4'h8);
        end
        report_and_stop();
    end
endmodule
`default_nettype wire
